// *** inc/led_pwm_defs.svh ***
// Constants for the grayscale PWM and status block.
`ifndef LED_PWM_DEFS_SVH
`define LED_PWM_DEFS_SVH
`define NUM_CH 16
`define LEVEL_BITS 12
`define DC_BITS 6
`define GRAY_PKT_BITS 192
`define DC_PKT_BITS 96
`define STATUS_THERMAL_BIT 16
`define STATUS_DC_LSB 24
`define STATUS_DC_MSB 119
`define CNT_MAX 12'hfff
`define CNT_LAST 12'hffe
`define CLK_PERIOD_NS 5
`define OPEN_FLAG_DELAY_NS 1060
`define CHANNEL_STEP_NS 30
`define OPEN_FLAG_DELAY_CYC ((`OPEN_FLAG_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CHANNEL_STEP_CYC ((`CHANNEL_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REG_SENSE_OFS 8'h00
`define REG_STATUS_OFS 8'h04
`define REG_OUTPUT_OFS 8'h08
`endif

// *** inc/led_pwm_pkg.sv ***
// Types for the grayscale PWM and status block.
package led_pwm_pkg;
    typedef enum logic [3:0] {
        PWM_BLANK = 4'b0001,
        PWM_ARMED = 4'b0010,
        PWM_RUN = 4'b0100,
        PWM_DONE = 4'b1000
    } pwm_state_t;
endpackage : led_pwm_pkg

// *** rtl/pin_sync.sv ***
// Two-stage synchroniser for pin inputs.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Data.
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : pin_sync
`default_nettype wire

// *** rtl/open_led_detect.sv ***
// Per-channel open-LED flag qualification after sink turn-on.
`timescale 1ns/100ps
`default_nettype none
`include "led_pwm_defs.svh"
module open_led_detect #(
    parameter int CH = `NUM_CH,
    parameter int DELAY_CYC = `OPEN_FLAG_DELAY_CYC,
    parameter int STEP_CYC = `CHANNEL_STEP_CYC,
    parameter int CNT_W = 10
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Cycle control.
    input wire logic start,
    input wire logic running,
    // Channel state.
    input wire logic [CH-1:0] sink_on,
    input wire logic [CH-1:0] sense,
    output logic [CH-1:0] flag
);
    localparam logic [CNT_W-1:0] SAT = {CNT_W{1'b1}};
    logic [CNT_W-1:0] elapsed_r;
    logic [CH-1:0] valid;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            elapsed_r <= '0;
        end else if (start) begin
            elapsed_r <= '0;
        end else if (running && elapsed_r != SAT) begin
            elapsed_r <= elapsed_r + 1'b1;
        end
    end

    // Each channel becomes valid one channel step later than the one below it.
    for (genvar n = 0; n < CH; n++) begin : g_ch
        localparam int TH = DELAY_CYC + n * STEP_CYC;
        assign valid[n] = (elapsed_r >= CNT_W'(TH));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= '0;
        end else begin
            flag <= sink_on & sense & valid & {CH{running}};
        end
    end
endmodule : open_led_detect
`default_nettype wire

// *** rtl/led_grayscale_pwm_status.sv ***
// Sixteen-channel grayscale PWM engine with serial data path and status readback.
//
// Overview of operation
// - Grayscale packet: sixteen 12-bit values, 192 bits, most significant bit first.
// - Mode select low: 192-bit shift register, grayscale entry mode.
// - Latch strobe rise in grayscale mode copies shift register to grayscale values.
// - First grayscale load after dot correction completes on one extra serial clock.
// - After a grayscale update the shift register is overwritten with status.
// - Status: open flags bits 0-15, thermal bit 16, dot correction bits 24-119.
// - Serial out shows status MSB at load, then next lower bit each clock.
// - Status is loaded only in grayscale mode.
// - Any active open-LED flag pulls the open-drain error output low.
// - Open flag valid fixed delay after turn-on, plus 30 ns per channel.
// - Open flags are captured into status when the latch strobe falls.
// - A PWM cycle begins on the falling edge of blanking.
// - First grayscale clock after blanking low: counter one, nonzero channels on.
// - Later grayscale clocks increment counter and switch off matching channels.
// - At counter FFFh counting stops and all outputs turn off.
// - Raising blanking resets the counter at once and ends the cycle.
// - Duty equals grayscale value over 4095; zero stays off.
// - Mode select high: 96-bit shift register, dot-correction entry mode.
// - Blanking high forces all outputs off and holds the counter reset.
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "led_pwm_defs.svh"
module led_grayscale_pwm_status
    import led_pwm_pkg::*;
#(
    parameter int CH = `NUM_CH,
    parameter int LEVEL_W = `LEVEL_BITS,
    parameter int DC_W = `DC_BITS
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Serial cascade pins.
    input wire logic serial_clock,
    input wire logic serial_in,
    input wire logic latch_strobe,
    input wire logic mode_select,
    output logic serial_out,
    // PWM pins.
    input wire logic grayscale_clock,
    input wire logic blank,
    output logic [CH-1:0] channel_output,
    // Open-drain error pin.
    output logic error_output_n_out,
    output logic error_output_n_oe
);
    localparam int GSP = `GRAY_PKT_BITS;
    localparam int DCP = `DC_PKT_BITS;

    // Pin synchronisers.
    logic sclk_s, ser_in_s, lat_s, mode_s, gck_s, blank_s;
    pin_sync #(.WIDTH(6), .RST_VAL(6'h01)) u_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .d({serial_clock, serial_in, latch_strobe, mode_select, grayscale_clock, blank}),
        .q({sclk_s, ser_in_s, lat_s, mode_s, gck_s, blank_s})
    );

    logic sclk_d_r, lat_d_r, gck_d_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_d_r <= 1'b0;
            lat_d_r <= 1'b0;
            gck_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
            lat_d_r <= lat_s;
            gck_d_r <= gck_s;
        end
    end
    wire sclk_rise = sclk_s & ~sclk_d_r;
    wire lat_rise = lat_s & ~lat_d_r;
    wire lat_fall = ~lat_s & lat_d_r;
    wire gck_rise = gck_s & ~gck_d_r;

    // Registers.
    logic [GSP-1:0] sr_r, level_r;
    logic [DCP-1:0] dc_r;
    logic [CH:0] sense_r;
    logic [CH-1:0] open_cap_r, on_r, open_flag;
    logic dc_pend_r, extra_wait_r, ser_out_r, err_oe_r;
    logic [11:0] cnt_r;
    pwm_state_t state_r, state_nxt;

    function automatic logic [LEVEL_W-1:0] level_of(input logic [GSP-1:0] v, input int n);
        level_of = v[n*LEVEL_W +: LEVEL_W];
    endfunction : level_of

    // Serial data path.
    wire gray_latch = lat_rise & ~mode_s;
    wire gray_commit = (gray_latch & ~dc_pend_r) | (extra_wait_r & sclk_rise);
    wire thermal_flag = sense_r[CH];
    wire [GSP-1:0] status_packet = {72'h0, dc_r, 7'h0, thermal_flag, open_cap_r};
    wire [GSP-1:0] sr_shift = {sr_r[GSP-2:0], ser_in_s};
    wire [GSP-1:0] sr_capt = {sr_r[GSP-1:CH+1], thermal_flag, open_flag};
    wire lat_fall_gray = lat_fall & ~mode_s;
    wire [GSP-1:0] sr_nxt = gray_commit ? status_packet :
                            (lat_fall_gray & ~extra_wait_r) ? sr_capt :
                            (sclk_rise & ~extra_wait_r) ? sr_shift : sr_r;
    wire ser_out_nxt = mode_s ? sr_nxt[DCP-1] : sr_nxt[GSP-1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sr_r <= '0;
            ser_out_r <= 1'b0;
        end else begin
            sr_r <= sr_nxt;
            ser_out_r <= ser_out_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_r <= '0;
        end else if (gray_commit) begin
            level_r <= sr_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dc_r <= '0;
        end else if (mode_s && lat_s) begin
            dc_r <= sr_r[DCP-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dc_pend_r <= 1'b0;
            extra_wait_r <= 1'b0;
        end else begin
            if (mode_s && lat_s) begin
                dc_pend_r <= 1'b1;
            end else if (gray_latch) begin
                dc_pend_r <= 1'b0;
            end
            if (gray_latch && dc_pend_r) begin
                extra_wait_r <= 1'b1;
            end else if (sclk_rise) begin
                extra_wait_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            open_cap_r <= '0;
        end else if (lat_fall_gray) begin
            open_cap_r <= open_flag;
        end
    end

    // PWM engine.
    wire first_step = (state_r == PWM_ARMED) & gck_rise & ~blank_s;
    wire run_step = (state_r == PWM_RUN) & gck_rise & ~blank_s;
    wire [11:0] cnt_inc = 12'(cnt_r + 12'h001);
    wire hit_max = run_step & (cnt_r == `CNT_LAST);
    wire [CH-1:0] lvl_nz;
    wire [CH-1:0] lvl_eq;
    wire [CH-1:0] on_nxt;
    for (genvar n = 0; n < CH; n++) begin : g_cmp
        assign lvl_nz[n] = (level_of(level_r, n) != 12'h000);
        assign lvl_eq[n] = (level_of(level_r, n) == cnt_r);
    end
    assign on_nxt = blank_s ? '0 :
                    first_step ? lvl_nz :
                    hit_max ? '0 :
                    run_step ? (on_r & ~lvl_eq) : on_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PWM_BLANK: begin
                if (!blank_s) begin
                    state_nxt = PWM_ARMED;
                end
            end
            PWM_ARMED: begin
                if (blank_s) begin
                    state_nxt = PWM_BLANK;
                end else if (gck_rise) begin
                    state_nxt = PWM_RUN;
                end
            end
            PWM_RUN: begin
                if (blank_s) begin
                    state_nxt = PWM_BLANK;
                end else if (hit_max) begin
                    state_nxt = PWM_DONE;
                end
            end
            PWM_DONE: begin
                if (blank_s) begin
                    state_nxt = PWM_BLANK;
                end
            end
            default: begin
                state_nxt = PWM_BLANK;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= PWM_BLANK;
            cnt_r <= 12'h000;
            on_r <= '0;
        end else begin
            state_r <= state_nxt;
            on_r <= on_nxt;
            if (blank_s) begin
                cnt_r <= 12'h000;
            end else if (first_step || (run_step && cnt_r != `CNT_MAX)) begin
                cnt_r <= cnt_inc;
            end
        end
    end

    // Open-LED detection and error pin.
    open_led_detect #(.CH(CH)) u_open (
        .clk(hclk),
        .rst_n(hresetn),
        .start(first_step),
        .running(state_r == PWM_RUN),
        .sink_on(on_r),
        .sense(sense_r[CH-1:0]),
        .flag(open_flag)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_oe_r <= 1'b0;
        end else begin
            err_oe_r <= |open_flag;
        end
    end

    // AHB-Lite register slave, zero wait states.
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [31:0] rdata_r;
    wire ahb_go = hsel & htrans[1] & hready;
    wire [7:0] a_ofs = haddr[7:0];
    wire [31:0] rd_mux = (a_ofs == `REG_SENSE_OFS) ? {15'h0, sense_r} :
                         (a_ofs == `REG_STATUS_OFS) ? {13'h0, err_oe_r, dc_pend_r,
                                                       mode_s, state_r, cnt_r} :
                         (a_ofs == `REG_OUTPUT_OFS) ? {open_flag, on_r} : 32'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rdata_r <= 32'h0;
        end else begin
            wr_pend_r <= ahb_go & hwrite;
            wr_addr_r <= a_ofs;
            if (ahb_go && !hwrite) begin
                rdata_r <= rd_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sense_r <= '0;
        end else if (wr_pend_r && wr_addr_r == `REG_SENSE_OFS) begin
            sense_r <= hwdata[CH:0];
        end
    end

    logic hready_r;
    assign hreadyout = hready_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hready_r <= 1'b1;
        end else begin
            hready_r <= 1'b1;
        end
    end

    assign hresp = 1'b0;
    assign hrdata = rdata_r;
    assign serial_out = ser_out_r;
    assign channel_output = on_r;
    assign error_output_n_out = 1'b0;
    assign error_output_n_oe = err_oe_r;

    // Checks.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    status_load_a: assert property (gray_commit |=>
        sr_r[`STATUS_DC_MSB:`STATUS_DC_LSB] == dc_r && sr_r[GSP-1:`STATUS_DC_MSB+1] == '0)
        else $error("status packet not loaded");
    serial_out_msb_a: assert property (gray_commit |=> serial_out == 1'b0)
        else $error("serial out not at status msb");
    err_pull_a: assert property (|open_flag |=> error_output_n_oe)
        else $error("error output not pulled");
    blank_off_a: assert property (blank_s |=> channel_output == '0 && cnt_r == 12'h000)
        else $error("blanking did not clear outputs");
    first_on_a: assert property (first_step |=> cnt_r == 12'h001
        && channel_output == $past(lvl_nz)) else $error("first grayscale step wrong");
    count_step_a: assert property (run_step && cnt_r != `CNT_MAX |=>
        cnt_r == 12'($past(cnt_r) + 12'h001)) else $error("counter did not step");
    cnt_stop_a: assert property (state_r == PWM_DONE |-> cnt_r == `CNT_MAX
        && channel_output == '0) else $error("counter not stopped at max");
    extra_clk_a: assert property (gray_latch && dc_pend_r |=> level_r == $past(level_r)
        && extra_wait_r) else $error("grayscale update not deferred");
    dc_latch_a: assert property (mode_s && lat_s |=> dc_r == $past(sr_r[DCP-1:0]))
        else $error("dot correction not latched");
endmodule : led_grayscale_pwm_status
`default_nettype wire

// *** tb/display_ctrl_model.sv ***
// Behavioural display controller driving the serial cascade and PWM pins.
`timescale 1ns/100ps
`default_nettype none
module display_ctrl_model (
    // Clock.
    input wire logic hclk,
    // Serial cascade pins.
    input wire logic serial_out,
    output logic serial_clock,
    output logic serial_in,
    output logic latch_strobe,
    output logic mode_select,
    // PWM pins.
    output logic grayscale_clock,
    output logic blank
);
    initial begin
        serial_clock = 1'b0;
        serial_in = 1'b0;
        latch_strobe = 1'b0;
        mode_select = 1'b0;
        grayscale_clock = 1'b0;
        blank = 1'b1;
    end

    // Sends n bits from bit n-1 down and collects the returned bits.
    task automatic shift_bits(input logic [191:0] d, input int n, output logic [191:0] cap);
        cap = '0;
        @(posedge hclk);
        #1.3;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in <= d[i];
            #24;
            cap = {cap[190:0], serial_out};
            serial_clock <= 1'b1;
            #24;
            serial_clock <= 1'b0;
        end
        #24;
    endtask : shift_bits

    // Gives one high pulse on the latch strobe.
    task automatic latch_pulse();
        @(posedge hclk);
        #1.3;
        latch_strobe <= 1'b1;
        #48;
        latch_strobe <= 1'b0;
        #48;
    endtask : latch_pulse

    // Changes the mode while the strobe stays low.
    task automatic set_mode(input logic m);
        @(posedge hclk);
        #1.3;
        mode_select <= m;
        #48;
    endtask : set_mode

    // Changes the blanking level.
    task automatic set_blank(input logic b);
        @(posedge hclk);
        #1.3;
        blank <= b;
        #48;
    endtask : set_blank

    // Gives n grayscale clock pulses.
    task automatic gray_pulses(input int n);
        @(posedge hclk);
        #1.3;
        repeat (n) begin
            grayscale_clock <= 1'b1;
            #20;
            grayscale_clock <= 1'b0;
            #20;
        end
    endtask : gray_pulses
endmodule : display_ctrl_model
`default_nettype wire

// *** tb/test_led_grayscale_pwm_status.sv ***
// Self-checking testbench of the grayscale PWM and status block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin fails++; $display("mismatch %s expected %h seen %h", what, exp, got); end end
module test_led_grayscale_pwm_status;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout, hresp, serial_out, oe_n_out, oe_n_en;
    logic [31:0] hrdata;
    logic [15:0] channel_output;
    logic sclk, ser_in, latch, mode, gray_clk, blank;
    logic [191:0] gray_pkt;
    logic [191:0] cap;
    logic [31:0] rd;
    logic [95:0] dc_pat = 96'hd53c_9617_e4d2_0b87_c1f3_6a95;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;

    always #2.5 hclk = ~hclk;

    led_grayscale_pwm_status i_led_grayscale_pwm_status (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serial_clock(sclk),
        .serial_in(ser_in), .latch_strobe(latch), .mode_select(mode), .serial_out(serial_out),
        .grayscale_clock(gray_clk), .blank(blank), .channel_output(channel_output),
        .error_output_n_out(oe_n_out), .error_output_n_oe(oe_n_en));

    display_ctrl_model i_display_ctrl_model (
        .hclk(hclk), .serial_out(serial_out), .serial_clock(sclk), .serial_in(ser_in),
        .latch_strobe(latch), .mode_select(mode), .grayscale_clock(gray_clk), .blank(blank));

    task automatic results();
        $display("mismatches %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 80000) begin
            fails++;
            results();
        end
    end

    task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        `CHK("response", 1'b0, hresp)
    endtask : ahb

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
                          input string what);
        ahb(a, 1'b0, 32'h0);
        `CHK(what, e, rd & m)
    endtask : rd_chk

    function automatic logic [191:0] st(input logic [15:0] flags, input logic th);
        return {72'h0, dc_pat, 7'h0, th, flags};
    endfunction : st

    task automatic shift_chk(input logic [191:0] e);
        i_display_ctrl_model.shift_bits(gray_pkt, 192, cap);
        `CHK("status packet", e, cap)
    endtask : shift_chk

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        for (int n = 0; n < 16; n++) begin
            gray_pkt[12*n +: 12] = (n == 15) ? 12'hfff : 12'(n);
        end
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(32'h00, '1, 32'h0, "sense reset");
        rd_chk(32'h04, '1, 32'h1000, "status reset");
        rd_chk(32'h08, '1, 32'h0, "output reset");
        rd_chk(32'h0c, '1, 32'h0, "unmapped");
        ahb(32'h04, 1'b1, 32'hffff_ffff);
        rd_chk(32'h04, '1, 32'h1000, "status read only");
        ahb(32'h00, 1'b1, 32'h0001_8000);
        rd_chk(32'h00, '1, 32'h0001_8000, "sense");
        i_display_ctrl_model.set_mode(1'b1);
        i_display_ctrl_model.shift_bits({96'h0, dc_pat}, 96, cap);
        i_display_ctrl_model.latch_pulse();
        `CHK("dc mode serial out", dc_pat[95], serial_out)
        rd_chk(32'h04, 32'h2_0000, 32'h2_0000, "dc pending");
        i_display_ctrl_model.set_mode(1'b0);
        i_display_ctrl_model.shift_bits(gray_pkt, 192, cap);
        i_display_ctrl_model.latch_pulse();
        `CHK("update deferred", gray_pkt[191], serial_out)
        rd_chk(32'h04, 32'h2_0000, 32'h0, "dc pending cleared");
        i_display_ctrl_model.shift_bits(gray_pkt, 1, cap);
        shift_chk(st(16'h0, 1'b1));
        i_display_ctrl_model.latch_pulse();
        i_display_ctrl_model.set_blank(1'b0);
        for (int m = 1; m <= 16; m++) begin
            i_display_ctrl_model.gray_pulses(1);
            `CHK("outputs", 16'(32'hffff << m) | 16'h8000, channel_output)
        end
        repeat (100) @(posedge hclk);
        `CHK("error early", 1'b0, oe_n_en)
        repeat (90) @(posedge hclk);
        `CHK("error active", 1'b1, oe_n_en)
        `CHK("error level", 1'b0, oe_n_out)
        shift_chk(st(16'h0, 1'b1));
        i_display_ctrl_model.latch_pulse();
        shift_chk(st(16'h8000, 1'b1));
        i_display_ctrl_model.gray_pulses(4079);
        rd_chk(32'h04, 32'hfff, 32'hfff, "counter at end");
        `CHK("outputs at end", 16'h0, channel_output)
        i_display_ctrl_model.gray_pulses(1);
        rd_chk(32'h04, 32'hfff, 32'hfff, "counter stopped");
        i_display_ctrl_model.set_blank(1'b1);
        `CHK("outputs blanked", 16'h0, channel_output)
        rd_chk(32'h04, 32'hffff, 32'h1000, "counter reset");
        i_display_ctrl_model.set_blank(1'b0);
        i_display_ctrl_model.gray_pulses(5);
        rd_chk(32'h04, 32'hfff, 32'h5, "counter mid cycle");
        `CHK("outputs mid cycle", 16'hffe0, channel_output)
        i_display_ctrl_model.set_blank(1'b1);
        rd_chk(32'h04, 32'hfff, 32'h0, "early blank");
        results();
    end
endmodule : test_led_grayscale_pwm_status
`default_nettype wire
